// *** core/roi_format_status_registers.sv ***
// roi_format_status_registers: depth inquiry, mosaic phase report and
// setting validity quadlets, plus the gate that holds off image capture.
// assumes: the link layer hands over one quadlet access at a time on
// req_i and takes the answer on rsp_o; settings come from the same clock.
//
// Behaviour
// - depth quadlet top byte shows read-only effective depth from pixel format
// - formats 0 and 9 report 8 bits per pixel
// - format 2 reports 8 bits per component
// - formats 5 and 10 report 12 bits per pixel
// - phase quadlet top byte shows one of four mosaic phases for region
// - phase is meaningful only on colour units, monochrome content is don't-care
// - validity bit 0 is read-only presence, always 1
// - validity bit 1 has no effect and reads zero
// - validity bit 8 flags unacceptable speed, position, size or format
// - validity bit 9 flags bad packet size, updated on each packet size write
// - capture never starts while either error bit is set
// - host bit 0 is the most significant bit of a quadlet
// - a frame needing more than 4095 packets makes the packet size bad
`timescale 1ns/1ps
module roi_format_status_registers #(
  parameter bit COLOR_FILTER = 1'b1,
  parameter logic [15:0] SENSOR_WIDTH = roi_status_pkg::SENSOR_WIDTH,
  parameter logic [15:0] SENSOR_HEIGHT = roi_status_pkg::SENSOR_HEIGHT
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire roi_status_pkg::reg_req_t req_i,
  output roi_status_pkg::reg_rsp_t rsp_o,
  input wire roi_status_pkg::roi_settings_t settings_i,
  input wire logic [15:0] packet_size_i,
  input wire logic packet_size_write_i,
  input wire logic capture_request_i,
  output logic capture_start_o,
  output logic capture_refused_o
);

  ////////////////////////////////////////////////////////////////////////////
  // format decode and validity checking

  logic [7:0] depth_comb;
  logic [1:0] bytes_per_pixel;
  logic format_supported;
  logic region_error;
  logic packet_error;

  format_decode u_format_decode (
    .pixel_format_select_i(settings_i.pixel_format_select),
    .depth_o(depth_comb),
    .bytes_per_pixel_o(bytes_per_pixel),
    .supported_o(format_supported)
  );

  setting_checker #(
    .SENSOR_WIDTH(SENSOR_WIDTH),
    .SENSOR_HEIGHT(SENSOR_HEIGHT)
  ) u_setting_checker (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .settings_i(settings_i),
    .bytes_per_pixel_i(bytes_per_pixel),
    .supported_i(format_supported),
    .packet_size_i(packet_size_i),
    .packet_size_write_i(packet_size_write_i),
    .region_error_o(region_error),
    .packet_error_o(packet_error)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status state: depth and phase are registered views of the settings

  logic [7:0] depth;
  logic [7:0] phase;
  logic [7:0] next_depth;
  logic [7:0] next_phase;

  // phase follows the parity of the region origin against an rg/gb sensor
  always_comb begin
    next_depth = depth_comb;
    next_phase = roi_status_pkg::PHASE_RGGB;
    if (COLOR_FILTER) begin
      case ({settings_i.left[0], settings_i.top[0]})
        2'b00: next_phase = roi_status_pkg::PHASE_RGGB;
        2'b01: next_phase = roi_status_pkg::PHASE_GBRG;
        2'b10: next_phase = roi_status_pkg::PHASE_GRBG;
        default: next_phase = roi_status_pkg::PHASE_BGGR;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      depth <= roi_status_pkg::DEPTH_NONE;
      phase <= roi_status_pkg::PHASE_RGGB;
    end else begin
      depth <= next_depth;
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quadlet assembly, host bit n lands at index 31-n

  logic [31:0] depth_word;
  logic [31:0] phase_word;
  logic [31:0] validity_word;

  always_comb begin
    depth_word = 32'h0000_0000;
    depth_word[roi_status_pkg::FIELD_TOP_MSB:roi_status_pkg::FIELD_TOP_LSB] = depth;
    phase_word = 32'h0000_0000;
    phase_word[roi_status_pkg::FIELD_TOP_MSB:roi_status_pkg::FIELD_TOP_LSB] = phase;
    validity_word = 32'h0000_0000;
    validity_word[roi_status_pkg::PRESENCE_POS] = 1'b1;
    validity_word[roi_status_pkg::SETTING1_POS] = 1'b0;
    validity_word[roi_status_pkg::REGION_ERR_POS] = region_error;
    validity_word[roi_status_pkg::PACKET_ERR_POS] = packet_error;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: every access answered one cycle later

  roi_status_pkg::reg_rsp_t next_rsp;

  // writes are accepted but change nothing, all fields are read only here
  always_comb begin
    next_rsp = '0;
    if (req_i.valid) begin
      next_rsp.ack = 1'b1;
      if (req_i.offset == roi_status_pkg::OFS_DEPTH) begin
        next_rsp.rdata = req_i.write ? 32'h0000_0000 : depth_word;
      end else if (req_i.offset == roi_status_pkg::OFS_PHASE) begin
        next_rsp.rdata = req_i.write ? 32'h0000_0000 : phase_word;
      end else if (req_i.offset == roi_status_pkg::OFS_VALIDITY) begin
        next_rsp.rdata = req_i.write ? 32'h0000_0000 : validity_word;
      end else begin
        next_rsp.addr_error = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= next_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture gate

  logic next_capture_start;
  logic next_capture_refused;

  // a request turns into a start only while both error flags are clear
  always_comb begin
    next_capture_start = capture_request_i && !region_error && !packet_error;
    next_capture_refused = capture_request_i && (region_error || packet_error);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      capture_start_o <= 1'b0;
      capture_refused_o <= 1'b0;
    end else begin
      capture_start_o <= next_capture_start;
      capture_refused_o <= next_capture_refused;
    end
  end

endmodule // roi_format_status_registers

// *** core/roi_status_pkg.sv ***
// roi_status_pkg: offsets, field positions, codes and limits of the region
// format and validity status registers.
// assumes: 32-bit quadlet registers, bit 0 of the host view is the msb.
package roi_status_pkg;

  // register offsets from the mode base address
  localparam logic [11:0] OFS_DEPTH = 12'h054;
  localparam logic [11:0] OFS_PHASE = 12'h058;
  localparam logic [11:0] OFS_VALIDITY = 12'h07C;

  // host bit n sits at vector index 31-n
  localparam int FIELD_TOP_MSB = 31;
  localparam int FIELD_TOP_LSB = 24;
  localparam int PRESENCE_POS = 31;
  localparam int SETTING1_POS = 30;
  localparam int REGION_ERR_POS = 23;
  localparam int PACKET_ERR_POS = 22;

  // pixel format codes
  localparam logic [7:0] FMT_GRAY8 = 8'h00;
  localparam logic [7:0] FMT_YUV422 = 8'h02;
  localparam logic [7:0] FMT_GRAY16 = 8'h05;
  localparam logic [7:0] FMT_RAW8 = 8'h09;
  localparam logic [7:0] FMT_RAW16 = 8'h0A;

  // effective depths reported
  localparam logic [7:0] DEPTH_8 = 8'h08;
  localparam logic [7:0] DEPTH_12 = 8'h0C;
  localparam logic [7:0] DEPTH_NONE = 8'h00;

  // bytes carried per pixel for each format
  localparam logic [1:0] BPP_ONE = 2'h1;
  localparam logic [1:0] BPP_TWO = 2'h2;

  // mosaic phase codes
  localparam logic [7:0] PHASE_RGGB = 8'h00;
  localparam logic [7:0] PHASE_GBRG = 8'h01;
  localparam logic [7:0] PHASE_GRBG = 8'h02;
  localparam logic [7:0] PHASE_BGGR = 8'h03;

  // bus speed codes and packet limits
  localparam logic [1:0] SPEED_MAX_CODE = 2'h2;
  localparam logic [15:0] PACKET_BASE_BYTES = 16'h0400;
  localparam logic [33:0] MAX_PACKETS = 34'h0_0000_0FFF;
  localparam logic [15:0] PACKET_ALIGN_MASK = 16'h0003;

  // default sensor size
  localparam logic [15:0] SENSOR_WIDTH = 16'h056C;
  localparam logic [15:0] SENSOR_HEIGHT = 16'h040E;

  // one quadlet access from the link layer
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] offset;
    logic [31:0] wdata;
  } reg_req_t;

  // answer to a quadlet access
  typedef struct packed {
    logic ack;
    logic addr_error;
    logic [31:0] rdata;
  } reg_rsp_t;

  // region and format settings held by neighbouring registers
  typedef struct packed {
    logic [1:0] speed;
    logic [15:0] left;
    logic [15:0] top;
    logic [15:0] width;
    logic [15:0] height;
    logic [7:0] pixel_format_select;
  } roi_settings_t;

endpackage

// *** core/format_decode.sv ***
// format_decode: maps the pixel format code to its effective depth and
// the number of bytes each pixel occupies on the bus.
// assumes: purely combinational, registered by the caller.
`timescale 1ns/1ps
module format_decode (
  input wire logic [7:0] pixel_format_select_i,
  output logic [7:0] depth_o,
  output logic [1:0] bytes_per_pixel_o,
  output logic supported_o
);

  // depth table, unknown codes report zero and are flagged unsupported
  always_comb begin
    depth_o = roi_status_pkg::DEPTH_NONE;
    bytes_per_pixel_o = roi_status_pkg::BPP_ONE;
    supported_o = 1'b1;
    case (pixel_format_select_i)
      roi_status_pkg::FMT_GRAY8, roi_status_pkg::FMT_RAW8: begin
        depth_o = roi_status_pkg::DEPTH_8;
      end
      roi_status_pkg::FMT_YUV422: begin
        depth_o = roi_status_pkg::DEPTH_8;
        bytes_per_pixel_o = roi_status_pkg::BPP_TWO;
      end
      roi_status_pkg::FMT_GRAY16, roi_status_pkg::FMT_RAW16: begin
        depth_o = roi_status_pkg::DEPTH_12;
        bytes_per_pixel_o = roi_status_pkg::BPP_TWO;
      end
      default: begin
        supported_o = 1'b0;
      end
    endcase
  end

endmodule // format_decode

// *** core/setting_checker.sv ***
// setting_checker: judges the region/format/speed combination every cycle
// and the packet size on each write of the packet size register.
// assumes: settings come from logic on the same clock.
`timescale 1ns/1ps
module setting_checker #(
  parameter logic [15:0] SENSOR_WIDTH = roi_status_pkg::SENSOR_WIDTH,
  parameter logic [15:0] SENSOR_HEIGHT = roi_status_pkg::SENSOR_HEIGHT
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire roi_status_pkg::roi_settings_t settings_i,
  input wire logic [1:0] bytes_per_pixel_i,
  input wire logic supported_i,
  input wire logic [15:0] packet_size_i,
  input wire logic packet_size_write_i,
  output logic region_error_o,
  output logic packet_error_o
);

  logic next_region_error;
  logic next_packet_error;
  logic [16:0] right_edge;
  logic [16:0] bottom_edge;
  logic [15:0] speed_limit;
  logic [33:0] frame_bytes;
  logic [33:0] frame_capacity;

  // region must sit inside the sensor, speed and format must be known
  always_comb begin
    right_edge = {1'b0, settings_i.left} + {1'b0, settings_i.width};
    bottom_edge = {1'b0, settings_i.top} + {1'b0, settings_i.height};
    speed_limit = roi_status_pkg::PACKET_BASE_BYTES << settings_i.speed;
    // widen before multiplying so the pixel count of a full frame is not cut to 16 bits
    frame_bytes = 34'(settings_i.width) * 34'(settings_i.height) * 34'(bytes_per_pixel_i);
    frame_capacity = roi_status_pkg::MAX_PACKETS * 34'(packet_size_i);
    next_region_error = (settings_i.speed > roi_status_pkg::SPEED_MAX_CODE)
                     || !supported_i
                     || (settings_i.width == 16'h0000)
                     || (settings_i.height == 16'h0000)
                     || (right_edge > {1'b0, SENSOR_WIDTH})
                     || (bottom_edge > {1'b0, SENSOR_HEIGHT});
    next_packet_error = packet_error_o;
    if (packet_size_write_i) begin
      next_packet_error = (packet_size_i == 16'h0000)
                       || ((packet_size_i & roi_status_pkg::PACKET_ALIGN_MASK) != 16'h0000)
                       || (packet_size_i > speed_limit)
                       || (frame_bytes > frame_capacity);
    end
  end

  // flags are registered so the status word is glitch free
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      region_error_o <= 1'b0;
      packet_error_o <= 1'b0;
    end else begin
      region_error_o <= next_region_error;
      packet_error_o <= next_packet_error;
    end
  end

endmodule // setting_checker

// *** sim/roi_status_props.sv ***
// roi_status_props: port checks of the format and validity quadlets.
// assumes: bound to roi_format_status_registers, one clock domain.
`timescale 1ns/1ps
module roi_status_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire roi_status_pkg::reg_req_t req_i,
  input wire roi_status_pkg::reg_rsp_t rsp_o,
  input wire roi_status_pkg::roi_settings_t settings_i,
  input wire logic [15:0] packet_size_i,
  input wire logic packet_size_write_i,
  input wire logic capture_request_i,
  input wire logic capture_start_o,
  input wire logic capture_refused_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // reads of each quadlet
  wire logic rd = req_i.valid && !req_i.write;
  wire logic rd_dep = rd && req_i.offset == roi_status_pkg::OFS_DEPTH;
  wire logic rd_pha = rd && req_i.offset == roi_status_pkg::OFS_PHASE;
  wire logic rd_val = rd && req_i.offset == roi_status_pkg::OFS_VALIDITY;
  wire logic [7:0] fmt = settings_i.pixel_format_select;
  ////////////////////////////////////////////////////////////////////////////////
  depth_eight_a: assert property (
    rd_dep && $stable(settings_i) && !$past(rst_i) && fmt inside {8'h00, 8'h02, 8'h09}
    |=> rsp_o.rdata[31:24] == 8'h08) else $error("depth not 8");
  depth_twelve_a: assert property (
    rd_dep && $stable(settings_i) && !$past(rst_i) && fmt inside {8'h05, 8'h0A}
    |=> rsp_o.rdata[31:24] == 8'h0C) else $error("depth not 12");
  phase_order_a: assert property (
    rd_pha && $stable(settings_i) && !$past(rst_i) |=> rsp_o.rdata[31:24] ==
    {6'h00, $past(settings_i.left[0]), $past(settings_i.top[0])}) else $error("bad phase");
  presence_bit_a: assert property (
    rd_val |=> rsp_o.rdata[31:30] == 2'h2) else $error("presence bits wrong");
  reserved_zero_a: assert property (
    rsp_o.ack |-> rsp_o.rdata[21:0] == 22'h000000) else $error("reserved bits set");
  write_ignored_a: assert property (
    req_i.valid && req_i.write |=> rsp_o.ack && rsp_o.rdata == 32'h0000_0000)
    else $error("write answer wrong");
  addr_check_a: assert property (
    req_i.valid |=> rsp_o.ack && rsp_o.addr_error == !($past(req_i.offset) inside
    {12'h054, 12'h058, 12'h07C})) else $error("address answer wrong");
  region_flag_a: assert property (
    rd_val && settings_i.width == 16'h0000 && $past(settings_i.width) == 16'h0000 &&
    !$past(rst_i) |=> rsp_o.rdata[23]) else $error("region flag clear");
  packet_flag_a: assert property (
    packet_size_write_i && packet_size_i == 16'h0000 ##1 !packet_size_write_i ##1
    rd_val && !packet_size_write_i |=> rsp_o.rdata[22]) else $error("packet flag clear");
  capture_once_a: assert property (
    capture_request_i |=> capture_start_o ^ capture_refused_o) else $error("capture answer");
  capture_quiet_a: assert property (
    !capture_request_i |=> !capture_start_o && !capture_refused_o) else $error("stray capture");
endmodule // roi_status_props

bind roi_format_status_registers roi_status_props props_u (.clock_i(clock_i), .rst_i(rst_i),
  .req_i(req_i), .rsp_o(rsp_o), .settings_i(settings_i), .packet_size_i(packet_size_i),
  .packet_size_write_i(packet_size_write_i), .capture_request_i(capture_request_i),
  .capture_start_o(capture_start_o), .capture_refused_o(capture_refused_o));

// *** sim/host_model.sv ***
// host_model: bus host making one quadlet access at a time.
// assumes: the register port answers one cycle after the request edge.
`timescale 1ns/1ps
module host_model (
  input wire logic clock_i,
  output roi_status_pkg::reg_req_t req_o,
  input wire roi_status_pkg::reg_rsp_t rsp_i
);
  initial req_o = '0;
  // valid for one edge, bounded wait for ack, then stale data scrambled
  task access(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
    output roi_status_pkg::reg_rsp_t r);
    @(posedge clock_i);
    req_o <= '{valid: 1'b1, write: wr, offset: ofs, wdata: wd};
    @(posedge clock_i);
    req_o.valid <= 1'b0;
    r = '0;
    for (int n = 0; n < 4 && !r.ack; n++) begin
      @(posedge clock_i);
      r = rsp_i;
    end
    req_o.wdata <= ~wd;
    r.rdata[30] = 1'b0;
  endtask
endmodule // host_model

// *** sim/tb.sv ***
// tb: drives settings, packet size and capture, reads the quadlets.
// assumes: host_model makes the register accesses.
`timescale 1ns/1ps
module tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  roi_status_pkg::reg_req_t req;
  roi_status_pkg::reg_rsp_t rsp;
  roi_status_pkg::reg_rsp_t r;
  roi_status_pkg::roi_settings_t cfg = '0;
  logic [15:0] psize = 16'h0400;
  logic pwr = 1'b0;
  logic creq = 1'b0;
  logic cstart;
  logic crefuse;
  int fails = 0;
  int num_checks = 0;
  logic [7:0] fmts [6] = '{8'h00, 8'h02, 8'h05, 8'h09, 8'h0A, 8'h03};
  logic [7:0] dep [6] = '{8'h08, 8'h08, 8'h0C, 8'h08, 8'h0C, 8'h00};
  logic [11:0] offs [4] = '{12'h054, 12'h058, 12'h07C, 12'h060};
  logic [15:0] sizes [4] = '{16'h0000, 16'h0402, 16'h015C, 16'h0160};
  // 40 MHz clock
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  roi_format_status_registers dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
    .rsp_o(rsp), .settings_i(cfg), .packet_size_i(psize), .packet_size_write_i(pwr),
    .capture_request_i(creq), .capture_start_o(cstart), .capture_refused_o(crefuse));
  host_model host_u (.clock_i(clock_i), .req_o(req), .rsp_i(rsp));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [11:0] ofs, input logic [31:0] exp);
    host_u.access(1'b0, ofs, 32'h0000_0000, r);
    check(r, {2'h2, exp});
  endtask
  task pkt(input logic [15:0] s);
    @(posedge clock_i);
    psize <= s;
    pwr <= 1'b1;
    @(posedge clock_i);
    pwr <= 1'b0;
  endtask
  task cap(input logic go);
    @(posedge clock_i);
    creq <= 1'b1;
    @(posedge clock_i);
    creq <= 1'b0;
    @(posedge clock_i);
    check({32'h0, cstart, crefuse}, {32'h0, go, !go});
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (3000) @(posedge clock_i);
    fails++;
    wrap_up;
  end
  // test sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    cfg.width <= 16'h0100;
    cfg.height <= 16'h0100;
    pkt(16'h0400);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      cfg.pixel_format_select <= fmts[i];
      rd(12'h054, {dep[i], 24'h000000});
      rd(12'h07C, {8'h80, i == 5, 23'h000000});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      cfg.pixel_format_select <= 8'h00;
      cfg.left <= {15'h0000, i[1]};
      cfg.top <= {15'h0000, i[0]};
      rd(12'h058, {6'h00, i[1:0], 24'h000000});
    end
    for (int j = 0; j < 4; j++) begin
      host_u.access(1'b1, offs[j], 32'hFFFF_FFFF, r);
      check(r, {1'b1, j == 3, 32'h0000_0000});
    end
    rd(12'h07C, 32'h8000_0000);
    rd(12'h058, 32'h0300_0000);
    @(posedge clock_i);
    cfg <= '{speed: 2'h0, left: 16'h0000, top: 16'h0000, width: 16'h056C,
      height: 16'h040E, pixel_format_select: 8'h00};
    for (int k = 0; k < 4; k++) begin
      pkt(sizes[k]);
      rd(12'h07C, {9'h100, k < 3, 22'h000000});
      cap(k == 3);
    end
    @(posedge clock_i);
    cfg.width <= 16'h0000;
    rd(12'h07C, 32'h8080_0000);
    cap(1'b0);
    @(posedge clock_i);
    cfg.width <= 16'h056C;
    cfg.left <= 16'h0001;
    rd(12'h07C, 32'h8080_0000);
    @(posedge clock_i);
    cfg.left <= 16'h0000;
    rd(12'h07C, 32'h8000_0000);
    cap(1'b1);
    // packet size limit follows the bus speed, speed code above the maximum is refused
    pkt(16'h0800);
    rd(12'h07C, 32'h8040_0000);
    @(posedge clock_i);
    cfg.speed <= 2'h1;
    pkt(16'h0800);
    rd(12'h07C, 32'h8000_0000);
    @(posedge clock_i);
    cfg.speed <= 2'h3;
    rd(12'h07C, 32'h8080_0000);
    cap(1'b0);
    wrap_up;
  end
endmodule // tb
